// [rtl/ufc_pkg.sv]
// Package: register map, field positions and reset values of the UART flow-control block
package ufc_pkg;
  localparam int unsigned ADDR_W = 6;
  localparam logic [5:0] OFS_EFR     = 6'h00;
  localparam logic [5:0] OFS_MCR     = 6'h04;
  localparam logic [5:0] OFS_TCR     = 6'h08;
  localparam logic [5:0] OFS_IER     = 6'h0C;
  localparam logic [5:0] OFS_ISR     = 6'h10;
  localparam logic [5:0] OFS_FEATURE_CONTROL_REG    = 6'h14;
  localparam logic [5:0] OFS_RESUME_CHAR_ONE    = 6'h18;
  localparam logic [5:0] OFS_RESUME_CHAR_TWO    = 6'h1C;
  localparam logic [5:0] OFS_PAUSE_CHAR_ONE   = 6'h20;
  localparam logic [5:0] OFS_PAUSE_CHAR_TWO   = 6'h24;
  localparam logic [5:0] OFS_STATE   = 6'h28;
  // enhanced_feature_reg fields
  localparam int unsigned EFR_CTS    = 7;
  localparam int unsigned EFR_RTS    = 6;
  localparam int unsigned EFR_SPEC   = 5;
  localparam int unsigned EFR_ENH    = 4;
  // modem_control_reg fields
  localparam int unsigned MCR_ANY    = 5;
  localparam int unsigned MCR_RTS    = 1;
  // irq_enable_reg / irq_status_reg fields
  localparam int unsigned IER_CTS    = 7;
  localparam int unsigned IER_RTS    = 6;
  localparam int unsigned IER_XOFF   = 5;
  localparam int unsigned ISR_FLOW   = 5;
  localparam int unsigned ISR_XOFF   = 4;
  // feature_control_reg trigger table select
  localparam logic [1:0] TABLE_D     = 2'b11;
  // Flow character selections
  localparam logic [1:0] SEL_NONE    = 2'b00;
  localparam logic [1:0] SEL_ONE     = 2'b10;
  localparam logic [1:0] SEL_TWO     = 2'b01;
  localparam logic [1:0] SEL_BOTH    = 2'b11;
  // Reset values
  localparam logic [7:0] RST_EFR     = 8'h00;
  localparam logic [7:0] RST_MCR     = 8'h00;
  localparam logic [7:0] RST_TCR     = 8'h00;
  localparam logic [7:0] RST_IER     = 8'h00;
  localparam logic [7:0] RST_FEATURE_CONTROL_REG    = 8'h20;
  localparam logic [7:0] RST_CHAR    = 8'h00;
endpackage

// [rtl/ufc_flow_ctrl.sv]
// Flow-control logic of one UART channel: auto RTS/CTS, Xon/Xoff and special character
`timescale 1ns/10ps
`default_nettype none
module ufc_flow_ctrl #(
  parameter int unsigned LVL_W = 7
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [5:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  input  wire logic [LVL_W-1:0] rx_level_i,
  input  wire logic [LVL_W-1:0] rx_trig_i,
  input  wire logic [LVL_W-1:0] rx_trig_up_i,
  input  wire logic [LVL_W-1:0] rx_trig_down_i,
  input  wire logic             rx_full_i,
  input  wire logic             rx_valid_i,
  input  wire logic [7:0]       rx_char_i,
  input  wire logic             cts_n_i,
  input  wire logic             tx_flow_ready_i,
  output logic                  rts_n_o,
  output logic                  tx_hold_o,
  output logic                  xoff_seen_out_n_o,
  output logic                  rx_store_o,
  output logic [7:0]            rx_store_char_o,
  output logic                  tx_flow_valid_o,
  output logic [7:0]            tx_flow_char_o,
  output logic                  flow_irq_o
);
  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {UFC_RX_IDLE, UFC_RX_PAUSE1, UFC_RX_RESUME1} ufc_rx_t;
  typedef enum logic [1:0] {UFC_TX_IDLE, UFC_TX_FIRST, UFC_TX_SECOND} ufc_tx_t;

  logic [7:0] enhanced_feature_reg;
  logic [7:0] modem_control_reg;
  logic [7:0] flow_level_reg;
  logic [7:0] irq_enable_reg;
  logic [7:0] feature_control_reg;
  logic [7:0] resume_char_one;
  logic [7:0] resume_char_two;
  logic [7:0] pause_char_one;
  logic [7:0] pause_char_two;
  logic       isr_xoff;
  logic       isr_flow;
  logic       xoff_halt;
  logic       sent_pause;
  logic       pause_is_next;
  logic       cts_prev;
  ufc_rx_t    rx_state;
  ufc_tx_t    tx_state;

  // Table D hysteresis in characters
  function automatic logic [7:0] hyst(input logic [3:0] code);
    logic [7:0] h;
    h = 8'h00;
    unique case (code)
      4'h0: h = 8'd0;
      4'h1: h = 8'd4;
      4'h2: h = 8'd6;
      4'h3: h = 8'd8;
      4'h4: h = 8'd8;
      4'h5: h = 8'd16;
      4'h6: h = 8'd24;
      4'h7: h = 8'd32;
      4'h8: h = 8'd40;
      4'h9: h = 8'd44;
      4'hA: h = 8'd48;
      4'hB: h = 8'd52;
      4'hC: h = 8'd12;
      4'hD: h = 8'd20;
      4'hE: h = 8'd28;
      4'hF: h = 8'd36;
    endcase
    return h;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Thresholds
  logic [7:0] lvl;
  logic [7:0] trig;
  logic [7:0] hys;
  logic       tbl_d;
  logic [7:0] rts_halt;
  logic [7:0] resume_lvl;
  logic [7:0] sw_halt;
  assign lvl   = 8'(rx_level_i);
  assign trig  = 8'(rx_trig_i);
  assign hys   = hyst(feature_control_reg[3:0]);
  assign tbl_d = feature_control_reg[5:4] == ufc_pkg::TABLE_D;
  assign rts_halt = (flow_level_reg[3:0] != 4'h0) ? {4'h0, flow_level_reg[3:0]} :
                    tbl_d ? 8'(trig + hys) : 8'(rx_trig_up_i);
  assign resume_lvl = (flow_level_reg[7:4] != 4'h0) ? {4'h0, flow_level_reg[7:4]} :
                      tbl_d ? ((trig > hys) ? 8'(trig - hys) : 8'h00) :
                      8'(rx_trig_down_i);
  assign sw_halt = (flow_level_reg[3:0] != 4'h0) ? {4'h0, flow_level_reg[3:0]} : trig;

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone classic slave
  logic bus_req;
  logic wr_stb;
  logic rd_isr;
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_stb  = bus_req && wb_we_i && wb_sel_i[0];
  assign rd_isr  = bus_req && !wb_we_i && wb_adr_i == ufc_pkg::OFS_ISR;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req && !wb_we_i) begin
      unique case (wb_adr_i)
        ufc_pkg::OFS_EFR:   wb_dat_o <= {24'h00_0000, enhanced_feature_reg};
        ufc_pkg::OFS_MCR:   wb_dat_o <= {24'h00_0000, modem_control_reg};
        ufc_pkg::OFS_TCR:   wb_dat_o <= {24'h00_0000, flow_level_reg};
        ufc_pkg::OFS_IER:   wb_dat_o <= {24'h00_0000, irq_enable_reg};
        ufc_pkg::OFS_ISR:   wb_dat_o <= {26'h000_0000, isr_flow, isr_xoff, 4'h0};
        ufc_pkg::OFS_FEATURE_CONTROL_REG:  wb_dat_o <= {24'h00_0000, feature_control_reg};
        ufc_pkg::OFS_RESUME_CHAR_ONE:  wb_dat_o <= {24'h00_0000, resume_char_one};
        ufc_pkg::OFS_RESUME_CHAR_TWO:  wb_dat_o <= {24'h00_0000, resume_char_two};
        ufc_pkg::OFS_PAUSE_CHAR_ONE: wb_dat_o <= {24'h00_0000, pause_char_one};
        ufc_pkg::OFS_PAUSE_CHAR_TWO: wb_dat_o <= {24'h00_0000, pause_char_two};
        ufc_pkg::OFS_STATE: wb_dat_o <= {28'h000_0000, sent_pause, xoff_halt, tx_hold_o, rts_n_o};
        default:            wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enhanced_feature_reg <= ufc_pkg::RST_EFR;
      modem_control_reg    <= ufc_pkg::RST_MCR;
      flow_level_reg       <= ufc_pkg::RST_TCR;
      irq_enable_reg       <= ufc_pkg::RST_IER;
      feature_control_reg  <= ufc_pkg::RST_FEATURE_CONTROL_REG;
      resume_char_one      <= ufc_pkg::RST_CHAR;
      resume_char_two      <= ufc_pkg::RST_CHAR;
      pause_char_one       <= ufc_pkg::RST_CHAR;
      pause_char_two       <= ufc_pkg::RST_CHAR;
    end else if (wr_stb) begin
      unique case (wb_adr_i)
        ufc_pkg::OFS_EFR:   enhanced_feature_reg <= wb_dat_i[7:0];
        ufc_pkg::OFS_MCR:   modem_control_reg    <= wb_dat_i[7:0];
        ufc_pkg::OFS_TCR:   flow_level_reg       <= wb_dat_i[7:0];
        ufc_pkg::OFS_IER: begin
          // Upper enables are locked unless enhanced features are on
          irq_enable_reg[3:0] <= wb_dat_i[3:0];
          if (enhanced_feature_reg[ufc_pkg::EFR_ENH]) begin
            irq_enable_reg[7:4] <= wb_dat_i[7:4];
          end
        end
        ufc_pkg::OFS_FEATURE_CONTROL_REG:  feature_control_reg  <= wb_dat_i[7:0];
        ufc_pkg::OFS_RESUME_CHAR_ONE:  resume_char_one      <= wb_dat_i[7:0];
        ufc_pkg::OFS_RESUME_CHAR_TWO:  resume_char_two      <= wb_dat_i[7:0];
        ufc_pkg::OFS_PAUSE_CHAR_ONE: pause_char_one       <= wb_dat_i[7:0];
        ufc_pkg::OFS_PAUSE_CHAR_TWO: pause_char_two       <= wb_dat_i[7:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Auto RTS
  logic next_rts_n;
  always_comb begin
    next_rts_n = !modem_control_reg[ufc_pkg::MCR_RTS];
    if (enhanced_feature_reg[ufc_pkg::EFR_RTS] && modem_control_reg[ufc_pkg::MCR_RTS]) begin
      if (lvl >= rts_halt) begin
        next_rts_n = 1'b1;
      end else if (lvl <= resume_lvl) begin
        next_rts_n = 1'b0;
      end else begin
        next_rts_n = rts_n_o;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rts_n_o <= 1'b1;
    end else begin
      rts_n_o <= next_rts_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive comparison
  logic [1:0] rx_sel;
  logic [1:0] tx_sel;
  logic       pair_seq;
  logic       is_p1;
  logic       is_p2;
  logic       is_r1;
  logic       is_r2;
  logic       single_pause;
  logic       single_resume;
  logic       special_hit;
  logic       pause_hit;
  logic       resume_hit;
  logic       consume;
  assign rx_sel   = enhanced_feature_reg[1:0];
  assign tx_sel   = enhanced_feature_reg[3:2];
  assign pair_seq = rx_sel == ufc_pkg::SEL_BOTH && tx_sel == ufc_pkg::SEL_BOTH;
  assign is_p1 = rx_char_i == pause_char_one;
  assign is_p2 = rx_char_i == pause_char_two;
  assign is_r1 = rx_char_i == resume_char_one;
  assign is_r2 = rx_char_i == resume_char_two;
  always_comb begin
    single_pause  = 1'b0;
    single_resume = 1'b0;
    unique case (rx_sel)
      ufc_pkg::SEL_ONE: begin
        single_pause  = is_p1;
        single_resume = is_r1;
      end
      ufc_pkg::SEL_TWO: begin
        single_pause  = is_p2;
        single_resume = is_r2;
      end
      ufc_pkg::SEL_BOTH: begin
        single_pause  = !pair_seq && (is_p1 || is_p2);
        single_resume = !pair_seq && (is_r1 || is_r2);
      end
      ufc_pkg::SEL_NONE: ;
    endcase
  end
  assign pause_hit   = rx_valid_i && (single_pause || (pair_seq && rx_state == UFC_RX_PAUSE1 && is_p2));
  assign resume_hit  = rx_valid_i && (single_resume || (pair_seq && rx_state == UFC_RX_RESUME1 && is_r2));
  assign special_hit = rx_valid_i && enhanced_feature_reg[ufc_pkg::EFR_SPEC] && is_p2 && !pause_hit;
  // Flow characters are consumed, everything else goes to the receive FIFO unless rx_full_i is set
  assign consume = pause_hit || resume_hit ||
                   (pair_seq && rx_state == UFC_RX_IDLE && (is_p1 || is_r1));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_state <= UFC_RX_IDLE;
    end else if (rx_valid_i) begin
      if (pair_seq && rx_state == UFC_RX_IDLE && is_p1) begin
        rx_state <= UFC_RX_PAUSE1;
      end else if (pair_seq && rx_state == UFC_RX_IDLE && is_r1) begin
        rx_state <= UFC_RX_RESUME1;
      end else begin
        rx_state <= UFC_RX_IDLE;
      end
    end
  end

  // Stores regardless of RTS#; a full FIFO or a consumed flow character stops it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_store_o      <= 1'b0;
      rx_store_char_o <= 8'h00;
    end else begin
      rx_store_o      <= rx_valid_i && !rx_full_i && !consume;
      rx_store_char_o <= rx_char_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xoff_halt         <= 1'b0;
      xoff_seen_out_n_o <= 1'b1;
    end else if (pause_hit) begin
      xoff_halt         <= 1'b1;
      xoff_seen_out_n_o <= 1'b0;
    end else if (resume_hit || (xoff_halt && rx_valid_i && modem_control_reg[ufc_pkg::MCR_ANY])) begin
      xoff_halt         <= 1'b0;
      xoff_seen_out_n_o <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit holdoff and CTS
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_hold_o <= 1'b0;
      cts_prev  <= 1'b1;
    end else begin
      // Transmitter finishes the current stop bit before honouring the hold
      tx_hold_o <= (enhanced_feature_reg[ufc_pkg::EFR_CTS] && cts_n_i) || xoff_halt;
      cts_prev  <= cts_n_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags; a set in the same cycle as the read-clear wins
  logic rts_edge;
  logic cts_edge;
  assign rts_edge = rts_n_o != next_rts_n;
  assign cts_edge = cts_n_i != cts_prev;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      isr_flow <= 1'b0;
      isr_xoff <= 1'b0;
    end else begin
      if ((irq_enable_reg[ufc_pkg::IER_RTS] && rts_edge) ||
          (irq_enable_reg[ufc_pkg::IER_CTS] && cts_edge)) begin
        isr_flow <= 1'b1;
      end else if (rd_isr) begin
        isr_flow <= 1'b0;
      end
      if ((pause_hit && irq_enable_reg[ufc_pkg::IER_XOFF]) || special_hit) begin
        isr_xoff <= 1'b1;
      end else if (resume_hit || rd_isr) begin
        isr_xoff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flow_irq_o <= 1'b0;
    end else begin
      flow_irq_o <= isr_flow || isr_xoff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit flow characters
  logic [7:0] first_char;
  logic [7:0] second_char;
  always_comb begin
    first_char  = pause_is_next ? pause_char_one : resume_char_one;
    second_char = pause_is_next ? pause_char_two : resume_char_two;
    if (tx_sel == ufc_pkg::SEL_TWO) begin
      first_char = second_char;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_state        <= UFC_TX_IDLE;
      sent_pause      <= 1'b0;
      pause_is_next   <= 1'b0;
      tx_flow_valid_o <= 1'b0;
      tx_flow_char_o  <= 8'h00;
    end else begin
      unique case (tx_state)
        UFC_TX_IDLE: begin
          if (tx_sel != ufc_pkg::SEL_NONE && !sent_pause && lvl >= sw_halt) begin
            tx_state        <= UFC_TX_FIRST;
            pause_is_next   <= 1'b1;
            sent_pause      <= 1'b1;
            tx_flow_valid_o <= 1'b1;
            tx_flow_char_o  <= (tx_sel == ufc_pkg::SEL_TWO) ? pause_char_two : pause_char_one;
          end else if (tx_sel != ufc_pkg::SEL_NONE && sent_pause && lvl < resume_lvl) begin
            tx_state        <= UFC_TX_FIRST;
            pause_is_next   <= 1'b0;
            sent_pause      <= 1'b0;
            tx_flow_valid_o <= 1'b1;
            tx_flow_char_o  <= (tx_sel == ufc_pkg::SEL_TWO) ? resume_char_two : resume_char_one;
          end
        end
        UFC_TX_FIRST: begin
          if (tx_flow_ready_i) begin
            if (tx_sel == ufc_pkg::SEL_BOTH) begin
              tx_state       <= UFC_TX_SECOND;
              tx_flow_char_o <= second_char;
            end else begin
              tx_state        <= UFC_TX_IDLE;
              tx_flow_valid_o <= 1'b0;
            end
          end
        end
        UFC_TX_SECOND: begin
          if (tx_flow_ready_i) begin
            tx_state        <= UFC_TX_IDLE;
            tx_flow_valid_o <= 1'b0;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_rts_manual;
    @(posedge clk_i) disable iff (rst_i)
      !enhanced_feature_reg[ufc_pkg::EFR_RTS] |=> rts_n_o == !$past(modem_control_reg[ufc_pkg::MCR_RTS]);
  endproperty
  a_rts_manual: assert property (p_rts_manual) else $error("RTS not following control bit");

  property p_rts_halt;
    @(posedge clk_i) disable iff (rst_i)
      enhanced_feature_reg[ufc_pkg::EFR_RTS] && modem_control_reg[ufc_pkg::MCR_RTS] && lvl >= rts_halt
      |=> rts_n_o;
  endproperty
  a_rts_halt: assert property (p_rts_halt) else $error("RTS not raised at halt level");

  property p_rts_resume;
    @(posedge clk_i) disable iff (rst_i)
      enhanced_feature_reg[ufc_pkg::EFR_RTS] && modem_control_reg[ufc_pkg::MCR_RTS] &&
      lvl <= resume_lvl && lvl < rts_halt |=> !rts_n_o;
  endproperty
  a_rts_resume: assert property (p_rts_resume) else $error("RTS not lowered at resume level");

  property p_rts_irq;
    @(posedge clk_i) disable iff (rst_i)
      irq_enable_reg[ufc_pkg::IER_RTS] && rts_edge |=> isr_flow ##1 flow_irq_o;
  endproperty
  a_rts_irq: assert property (p_rts_irq) else $error("RTS change did not raise flow flag");

  property p_cts_hold;
    @(posedge clk_i) disable iff (rst_i)
      enhanced_feature_reg[ufc_pkg::EFR_CTS] && cts_n_i |=> tx_hold_o;
  endproperty
  a_cts_hold: assert property (p_cts_hold) else $error("CTS high did not hold transmitter");

  property p_pause_rx;
    @(posedge clk_i) disable iff (rst_i)
      pause_hit |=> !xoff_seen_out_n_o && xoff_halt ##1 tx_hold_o;
  endproperty
  a_pause_rx: assert property (p_pause_rx) else $error("Pause character did not halt");

  property p_special;
    @(posedge clk_i) disable iff (rst_i)
      special_hit && !rx_full_i && !consume && !modem_control_reg[ufc_pkg::MCR_ANY]
      |=> isr_xoff && rx_store_o && $stable(xoff_halt);
  endproperty
  a_special: assert property (p_special) else $error("Special character mishandled");

  property p_pause_tx;
    @(posedge clk_i) disable iff (rst_i)
      tx_state == UFC_TX_IDLE && tx_sel != ufc_pkg::SEL_NONE && !sent_pause && lvl >= sw_halt
      |=> tx_flow_valid_o && sent_pause;
  endproperty
  a_pause_tx: assert property (p_pause_tx) else $error("Pause character not sent");
endmodule
`default_nettype wire

// [bench/ufc_remote.sv]
// Remote UART model on the serial side of the flow-control block
`timescale 1ns/10ps
`default_nettype none
module ufc_remote (
  input  wire logic       clk_i,
  input  wire logic       rts_n_i,
  input  wire logic       tx_flow_valid_i,
  input  wire logic [7:0] tx_flow_char_i,
  output logic            rx_valid_o,
  output logic [7:0]      rx_char_o,
  output logic            cts_n_o,
  output logic            tx_flow_ready_o,
  output logic [7:0]      got_char_o
);
  initial begin
    rx_valid_o = 1'b0;
    rx_char_o = 8'h00;
    cts_n_o = 1'b0;
    tx_flow_ready_o = 1'b0;
    got_char_o = 8'h00;
  end
  // No new character while RTS# is high
  task automatic send(input logic [7:0] c);
    while (rts_n_i !== 1'b0) @(posedge clk_i);
    rx_valid_o <= 1'b1;
    rx_char_o <= c;
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_char_o <= ~c;
    @(posedge clk_i);
  endtask
  // Drives CTS# on the link
  task automatic set_cts(input logic v);
    cts_n_o <= v;
  endtask
  // Takes each flow character, one every other cycle
  always @(posedge clk_i) begin
    tx_flow_ready_o <= tx_flow_valid_i & ~tx_flow_ready_o;
    if (tx_flow_ready_o && tx_flow_valid_i) begin
      got_char_o <= tx_flow_char_i;
    end
  end
endmodule
`default_nettype wire

// [bench/uart_flow_control_tb.sv]
// Self-checking testbench of the flow-control block
`timescale 1ns/10ps
`default_nettype none
module uart_flow_control_tb;
  logic        clk_i, rst_i, cyc, stb, we, ack, rts_n, hold, xseen_n, store, fval, fready, irq, rxv, cts_n, full;
  logic [3:0]  sel;
  logic [5:0]  adr;
  logic [31:0] wdat, rdat;
  logic [6:0]  lvl, trig;
  logic [7:0]  rxc, fchar, schar, got, q;
  int          fail_count, n_compared;
  ufc_flow_ctrl ufc_flow_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .rx_level_i(lvl), .rx_trig_i(trig), .rx_trig_up_i(trig + 7'd4), .rx_trig_down_i(trig - 7'd4),
    .rx_full_i(full), .rx_valid_i(rxv), .rx_char_i(rxc), .cts_n_i(cts_n), .tx_flow_ready_i(fready),
    .rts_n_o(rts_n), .tx_hold_o(hold), .xoff_seen_out_n_o(xseen_n), .rx_store_o(store),
    .rx_store_char_o(schar), .tx_flow_valid_o(fval), .tx_flow_char_o(fchar), .flow_irq_o(irq));
  ufc_remote remote_inst (.clk_i(clk_i), .rts_n_i(rts_n), .tx_flow_valid_i(fval), .tx_flow_char_i(fchar),
    .rx_valid_o(rxv), .rx_char_o(rxc), .cts_n_o(cts_n), .tx_flow_ready_o(fready), .got_char_o(got));
  ////////////////////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h00_0000, d};
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic settle(input logic [6:0] l);
    lvl <= l;
    repeat (6) @(posedge clk_i);
  endtask
  ////////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    repeat (3000) @(posedge clk_i);
    fail_count++;
    report_and_stop();
  end
  initial begin
    rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 6'h00; wdat = 32'h0000_0000;
    lvl = 7'h00; trig = 7'h0A; fail_count = 0; n_compared = 0;
    sel = 4'h1;
    full = 1'b0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    xfer(1'b0, ufc_pkg::OFS_FEATURE_CONTROL_REG, 8'h00); chk("feature_control_reg reset", ufc_pkg::RST_FEATURE_CONTROL_REG, q);
    xfer(1'b0, 6'h3C, 8'h00); chk("unmapped", 8'h00, q);
    xfer(1'b1, ufc_pkg::OFS_EFR, 8'h50);
    xfer(1'b1, ufc_pkg::OFS_IER, 8'h40);
    xfer(1'b1, ufc_pkg::OFS_TCR, 8'h28);
    xfer(1'b1, ufc_pkg::OFS_MCR, 8'h02);
    settle(7'd7); chk("rts below halt", 8'h00, {7'h00, rts_n});
    xfer(1'b0, ufc_pkg::OFS_ISR, 8'h00);
    chk("isr rts low", 8'h20, q & 8'h30);
    settle(7'd8); chk("rts at halt", 8'h01, {7'h00, rts_n});
    chk("rts irq", 8'h01, {7'h00, irq});
    xfer(1'b0, ufc_pkg::OFS_ISR, 8'h00); chk("isr rts", 8'h20, q & 8'h30);
    chk("irq cleared", 8'h00, {7'h00, irq});
    settle(7'd3); chk("rts above resume", 8'h01, {7'h00, rts_n});
    settle(7'd2); chk("rts at resume", 8'h00, {7'h00, rts_n});
    xfer(1'b1, ufc_pkg::OFS_TCR, 8'h00);
    xfer(1'b1, ufc_pkg::OFS_FEATURE_CONTROL_REG, 8'h32);
    settle(7'd15);
    chk("tbl d below", 8'h00, {7'h00, rts_n});
    settle(7'd16);
    chk("tbl d halt", 8'h01, {7'h00, rts_n});
    settle(7'd5);
    chk("tbl d hysteresis", 8'h01, {7'h00, rts_n});
    settle(7'd4);
    chk("tbl d resume", 8'h00, {7'h00, rts_n});
    trig <= 7'd12;
    settle(7'd17);
    chk("trig below", 8'h00, {7'h00, rts_n});
    settle(7'd18);
    chk("trig halt", 8'h01, {7'h00, rts_n});
    settle(7'd6);
    chk("trig resume", 8'h00, {7'h00, rts_n});
    xfer(1'b1, ufc_pkg::OFS_FEATURE_CONTROL_REG, 8'h00);
    xfer(1'b1, ufc_pkg::OFS_TCR, 8'h28);
    xfer(1'b1, ufc_pkg::OFS_PAUSE_CHAR_ONE, 8'h13);
    xfer(1'b1, ufc_pkg::OFS_RESUME_CHAR_ONE, 8'h11);
    xfer(1'b1, ufc_pkg::OFS_EFR, 8'h0A);
    settle(7'd8); chk("pause sent", 8'h13, got);
    settle(7'd1); chk("resume sent", 8'h11, got);
    remote_inst.send(8'h13); settle(7'd1); chk("xoff seen", 8'h00, {7'h00, xseen_n});
    chk("halted", 8'h01, {7'h00, hold});
    remote_inst.send(8'h11); settle(7'd1); chk("resumed", 8'h00, {7'h00, hold});
    remote_inst.send(8'h41);
    chk("stored", 8'h41, schar);
    chk("store pulse", 8'h01, {7'h00, store});
    full <= 1'b1;
    remote_inst.send(8'h42);
    chk("full no store", 8'h00, {7'h00, store});
    full <= 1'b0;
    xfer(1'b1, ufc_pkg::OFS_MCR, 8'h22);
    remote_inst.send(8'h13);
    chk("any paused", 8'h00, {7'h00, xseen_n});
    remote_inst.send(8'h45);
    chk("any resumed", 8'h01, {7'h00, xseen_n});
    chk("any stored", 8'h45, schar);
    settle(7'd1);
    chk("any hold", 8'h00, {7'h00, hold});
    xfer(1'b1, ufc_pkg::OFS_MCR, 8'h02);
    xfer(1'b1, ufc_pkg::OFS_PAUSE_CHAR_TWO, 8'h93);
    xfer(1'b1, ufc_pkg::OFS_EFR, 8'h22);
    remote_inst.send(8'h93);
    chk("special stored", 8'h93, schar);
    chk("special store", 8'h01, {7'h00, store});
    settle(7'd1);
    chk("special no halt", 8'h00, {7'h00, hold});
    xfer(1'b0, ufc_pkg::OFS_ISR, 8'h00);
    chk("special flag", 8'h10, q & 8'h10);
    xfer(1'b0, ufc_pkg::OFS_ISR, 8'h00);
    chk("special cleared", 8'h00, q & 8'h10);
    xfer(1'b1, ufc_pkg::OFS_RESUME_CHAR_TWO, 8'h91);
    xfer(1'b1, ufc_pkg::OFS_EFR, 8'h0F);
    settle(7'd8);
    chk("pause pair sent", 8'h93, got);
    settle(7'd1);
    chk("resume pair sent", 8'h91, got);
    remote_inst.send(8'h93);
    chk("lone second", 8'h01, {7'h00, xseen_n});
    chk("lone stored", 8'h93, schar);
    remote_inst.send(8'h13);
    remote_inst.send(8'h93);
    chk("pair pause", 8'h00, {7'h00, xseen_n});
    remote_inst.send(8'h11);
    remote_inst.send(8'h91);
    settle(7'd1);
    chk("pair resume", 8'h00, {7'h00, hold});
    xfer(1'b1, ufc_pkg::OFS_EFR, 8'h90);
    xfer(1'b1, ufc_pkg::OFS_IER, 8'h80);
    xfer(1'b0, ufc_pkg::OFS_ISR, 8'h00);
    remote_inst.set_cts(1'b1);
    settle(7'd1);
    chk("cts hold", 8'h01, {7'h00, hold});
    xfer(1'b0, ufc_pkg::OFS_ISR, 8'h00);
    chk("cts flag", 8'h20, q & 8'h30);
    remote_inst.set_cts(1'b0);
    settle(7'd1);
    chk("cts go", 8'h00, {7'h00, hold});
    sel <= 4'h0;
    xfer(1'b1, ufc_pkg::OFS_RESUME_CHAR_ONE, 8'h55);
    sel <= 4'h1;
    xfer(1'b0, ufc_pkg::OFS_RESUME_CHAR_ONE, 8'h00);
    chk("sel refused", 8'h11, q);
    report_and_stop();
  end
endmodule
`default_nettype wire
